// ==== design/sync_line_pkg.sv ====
/*
 * Shared constants and types for the sync line parameter and transmit control block.
 * Assumes a single 100 MHz system clock and registers reached by a plain select port.
 */
package sync_line_pkg;

    // Register selects
    localparam logic        SEL_PARAM = 1'b0;
    localparam logic        SEL_TRANSMIT_CONTROL_STATUS = 1'b1;

    // Parameter register fields
    localparam int          P_CHAR_MODE = 15;
    localparam int          P_SEC_MODE  = 12;
    localparam int          P_CRC_INH   = 9;
    localparam int          P_ADDR_LSB  = 0;
    localparam int          P_ADDR_W    = 8;

    // Transmit control/status fields
    localparam int          T_UNDERRUN  = 15;
    localparam int          T_MONITOR   = 14;
    localparam int          T_STEP_CLK  = 13;
    localparam int          T_DIAG_IN   = 10;

    // Reset values and CRC polynomial
    localparam logic [7:0]  ADDR_RST    = 8'h00;
    localparam logic [15:0] CRC_INIT    = 16'h0000;
    localparam logic [15:0] CRC_POLY    = 16'h1021;

    // Framing constants
    localparam logic [7:0]  FLAG_CHAR   = 8'h7e;
    localparam logic [2:0]  ONES_STUFF  = 3'h5;
    localparam logic [3:0]  CHAR_BITS   = 4'h8;
    localparam logic [4:0]  CRC_BITS    = 5'h10;

    // Buffering
    localparam int          FIFO_DEPTH  = 16;
    localparam int          WORD_W      = 10;

    typedef struct packed
    {
        logic       som;
        logic       eom;
        logic [7:0] data;
    } tx_word_t;

    typedef enum logic [2:0]
    {
        TX_IDLE  = 3'b000,
        TX_DATA  = 3'b001,
        TX_CRC   = 3'b010,
        TX_ABORT = 3'b011,
        TX_MARK  = 3'b100
    } tx_state_t;

endpackage

// ==== design/word_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-high clear.
 */
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 16
) (
    // Clock and clear
    input  wire logic             sys_clk,
    input  wire logic             clr,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r];

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem[wr_ptr_r] <= in_data;
    end

    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + AW'(1);
            if (pop)
                rd_ptr_r <= rd_ptr_r + AW'(1);
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow: assert property (@(posedge sys_clk) disable iff (clr)
        count_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule
`default_nettype wire

// ==== design/sync_line_param_tx_control.sv ====
/*
 * Line parameter and transmit control registers with a bit-serial transmitter and receiver.
 * Assumes modem bit clocks and data arrive asynchronously and are sampled on sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_line_param_tx_control (
    // Clock and resets
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        dev_reset,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_sel,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Transmit character buffer
    input  wire logic        tx_push_valid,
    output logic             tx_push_ready,
    input  wire sync_line_pkg::tx_word_t tx_char_buffer,
    output logic             tx_char_done,
    // Control levels
    input  wire logic        tx_send,
    input  wire logic        rx_enable,
    input  wire logic        diag_internal_mode,
    // Modem pins
    input  wire logic        modem_tx_clk,
    input  wire logic        modem_rx_clk,
    input  wire logic        modem_rx_data,
    output logic             tx_serial_out,
    // Receive events
    output logic             rx_addr_match,
    output logic             rx_sync_detect,
    output logic             rx_crc_error,
    output logic             rx_byte_valid,
    output logic      [7:0]  rx_byte
);
    logic        clr;
    logic        char_oriented_mode_r;
    logic        sec_mode_r;
    logic        crc_inhibit_r;
    logic [7:0]  station_addr_or_sync_char_r;
    logic        tx_underrun_error_r;
    logic        diag_step_clock_r;
    logic        diag_step_prev_r;
    logic        diag_serial_in_r;
    logic        step_rise;
    logic        step_fall;
    logic [2:0]  txc_sync_r;
    logic [2:0]  rxc_sync_r;
    logic [1:0]  rxd_sync_r;
    logic        tx_bit_en;
    logic        rx_bit_en;
    logic        rx_bit;
    sync_line_pkg::tx_state_t tx_state_r;
    sync_line_pkg::tx_word_t  fifo_word;
    sync_line_pkg::tx_word_t  cur_r;
    logic        fifo_valid;
    logic        fifo_pop;
    logic [3:0]  tx_cnt_r;
    logic [4:0]  crc_cnt_r;
    logic [2:0]  tx_ones_r;
    logic [15:0] tx_crc_r;
    logic        stuff_now;
    logic        char_end;
    logic        next_bit;
    logic [7:0]  raw_sr_r;
    logic [7:0]  rx_sr_r;
    logic [7:0]  sync_sr_r;
    logic [3:0]  rx_cnt_r;
    logic [2:0]  rx_ones_r;
    logic        first_char_r;
    logic        frame_data_r;
    logic [15:0] rx_crc_r;
    logic        stripped;
    logic [7:0]  rx_sr_nxt;
    logic [7:0]  sync_sr_nxt;

    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? sync_line_pkg::CRC_POLY : 16'h0000);
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] t;
        t = c;
        for (int i = 0; i < 8; i++)
            t = crc_bit(t, d[i]);
        crc_byte = t;
    endfunction

    assign clr = rst || dev_reset;

    // Register writes
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            char_oriented_mode_r        <= 1'b0;
            sec_mode_r                  <= 1'b0;
            crc_inhibit_r               <= 1'b0;
            station_addr_or_sync_char_r <= sync_line_pkg::ADDR_RST;
        end
        else if (reg_wr && reg_sel == sync_line_pkg::SEL_PARAM)
        begin
            char_oriented_mode_r        <= reg_wdata[sync_line_pkg::P_CHAR_MODE];
            sec_mode_r                  <= reg_wdata[sync_line_pkg::P_SEC_MODE];
            crc_inhibit_r               <= reg_wdata[sync_line_pkg::P_CRC_INH];
            station_addr_or_sync_char_r <= reg_wdata[sync_line_pkg::P_ADDR_LSB +: sync_line_pkg::P_ADDR_W];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            diag_step_clock_r <= 1'b0;
            diag_serial_in_r  <= 1'b0;
        end
        else if (reg_wr && reg_sel == sync_line_pkg::SEL_TRANSMIT_CONTROL_STATUS)
        begin
            diag_step_clock_r <= reg_wdata[sync_line_pkg::T_STEP_CLK];
            diag_serial_in_r  <= reg_wdata[sync_line_pkg::T_DIAG_IN];
        end
    end

    // Register reads; parameter register is write only
    always_ff @(posedge sys_clk)
    begin
        if (clr)
            reg_rdata <= 16'h0000;
        else if (reg_rd && reg_sel == sync_line_pkg::SEL_TRANSMIT_CONTROL_STATUS)
        begin
            reg_rdata                            <= 16'h0000;
            reg_rdata[sync_line_pkg::T_UNDERRUN] <= tx_underrun_error_r;
            reg_rdata[sync_line_pkg::T_MONITOR]  <= diag_internal_mode && tx_serial_out;
            reg_rdata[sync_line_pkg::T_STEP_CLK] <= diag_step_clock_r;
            reg_rdata[sync_line_pkg::T_DIAG_IN]  <= diag_serial_in_r;
        end
        else if (reg_rd)
            reg_rdata <= 16'h0000;
    end

    // Step clock edges on the system clock
    always_ff @(posedge sys_clk)
    begin
        if (clr)
            diag_step_prev_r <= 1'b0;
        else
            diag_step_prev_r <= diag_step_clock_r;
    end

    assign step_rise = diag_step_clock_r && !diag_step_prev_r;
    assign step_fall = !diag_step_clock_r && diag_step_prev_r;

    // Modem pin synchronisers
    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            txc_sync_r <= 3'h0;
            rxc_sync_r <= 3'h0;
            rxd_sync_r <= 2'h0;
        end
        else
        begin
            txc_sync_r <= {txc_sync_r[1:0], modem_tx_clk};
            rxc_sync_r <= {rxc_sync_r[1:0], modem_rx_clk};
            rxd_sync_r <= {rxd_sync_r[0], modem_rx_data};
        end
    end

    assign tx_bit_en = diag_internal_mode ? step_rise : (txc_sync_r[2] && !txc_sync_r[1]);
    assign rx_bit_en = diag_internal_mode ? step_fall : (!rxc_sync_r[2] && rxc_sync_r[1]);
    assign rx_bit    = diag_internal_mode ? diag_serial_in_r : rxd_sync_r[1];

    word_fifo #(
        .WIDTH (sync_line_pkg::WORD_W),
        .DEPTH (sync_line_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .sys_clk   (sys_clk),
        .clr       (clr),
        .in_valid  (tx_push_valid),
        .in_ready  (tx_push_ready),
        .in_data   (tx_char_buffer),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );

    assign tx_char_done = tx_push_ready;

    // Transmitter
    assign stuff_now = !char_oriented_mode_r && !cur_r.som && tx_ones_r == sync_line_pkg::ONES_STUFF;
    assign char_end  = tx_bit_en && tx_state_r == sync_line_pkg::TX_DATA && !stuff_now
                       && tx_cnt_r == sync_line_pkg::CHAR_BITS - 4'h1;
    assign fifo_pop  = fifo_valid && tx_send && tx_bit_en && !stuff_now &&
                       (tx_state_r == sync_line_pkg::TX_IDLE || tx_state_r == sync_line_pkg::TX_ABORT ||
                        tx_state_r == sync_line_pkg::TX_MARK ||
                        (char_end && !(cur_r.eom && !crc_inhibit_r)));
    assign next_bit  = (tx_state_r == sync_line_pkg::TX_CRC) ? tx_crc_r[15] : cur_r.data[tx_cnt_r[2:0]];

    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            tx_state_r    <= sync_line_pkg::TX_IDLE;
            cur_r         <= '0;
            tx_cnt_r      <= 4'h0;
            crc_cnt_r     <= 5'h00;
            tx_ones_r     <= 3'h0;
            tx_crc_r      <= sync_line_pkg::CRC_INIT;
            tx_serial_out <= 1'b1;
        end
        else if (!tx_send)
        begin
            tx_state_r    <= sync_line_pkg::TX_IDLE;
            tx_serial_out <= 1'b1;
            tx_ones_r     <= 3'h0;
        end
        else if (fifo_pop)
        begin
            tx_state_r    <= sync_line_pkg::TX_DATA;
            cur_r         <= fifo_word;
            tx_cnt_r      <= 4'h0;
            if (tx_state_r != sync_line_pkg::TX_DATA)
            begin
                tx_serial_out <= 1'b1;
                tx_ones_r     <= 3'h0;
            end
            else
            begin
                // Last bit of the previous character still counts for stuffing and CRC
                tx_serial_out <= next_bit;
                tx_ones_r     <= next_bit ? tx_ones_r + 3'h1 : 3'h0;
                if (!cur_r.som)
                    tx_crc_r  <= crc_bit(tx_crc_r, next_bit);
            end
            if (fifo_word.som)
                tx_crc_r  <= sync_line_pkg::CRC_INIT;
        end
        else if (tx_bit_en)
        begin
            unique case (tx_state_r)
                sync_line_pkg::TX_IDLE,
                sync_line_pkg::TX_MARK:
                    tx_serial_out <= 1'b1;
                sync_line_pkg::TX_ABORT:
                    tx_serial_out <= 1'b1;
                sync_line_pkg::TX_DATA,
                sync_line_pkg::TX_CRC:
                begin
                    if (stuff_now)
                    begin
                        tx_serial_out <= 1'b0;
                        tx_ones_r     <= 3'h0;
                    end
                    else
                    begin
                        tx_serial_out <= next_bit;
                        tx_ones_r     <= next_bit ? tx_ones_r + 3'h1 : 3'h0;
                        if (tx_state_r == sync_line_pkg::TX_CRC)
                        begin
                            tx_crc_r  <= {tx_crc_r[14:0], 1'b0};
                            crc_cnt_r <= crc_cnt_r + 5'h01;
                            if (crc_cnt_r == sync_line_pkg::CRC_BITS - 5'h01)
                                tx_state_r <= sync_line_pkg::TX_MARK;
                        end
                        else
                        begin
                            tx_cnt_r <= tx_cnt_r + 4'h1;
                            if (!cur_r.som)
                                tx_crc_r <= crc_bit(tx_crc_r, next_bit);
                            if (char_end)
                            begin
                                tx_cnt_r <= 4'h0;
                                if (cur_r.eom && !crc_inhibit_r)
                                begin
                                    tx_state_r <= sync_line_pkg::TX_CRC;
                                    crc_cnt_r  <= 5'h00;
                                end
                                else if (cur_r.eom)
                                    tx_state_r <= sync_line_pkg::TX_MARK;
                                else if (cur_r.som)
                                    tx_state_r <= sync_line_pkg::TX_DATA;
                                else
                                    tx_state_r <= char_oriented_mode_r ? sync_line_pkg::TX_MARK
                                        : sync_line_pkg::TX_ABORT;
                            end
                        end
                    end
                end
                default:
                    tx_state_r <= sync_line_pkg::TX_IDLE;
            endcase
        end
    end

    // Underrun error: set when the next character is missing at the end of a character that is neither start nor end of message
    always_ff @(posedge sys_clk)
    begin
        if (clr)
            tx_underrun_error_r <= 1'b0;
        else if (char_end && !fifo_valid && tx_send && !cur_r.som && !cur_r.eom)
            tx_underrun_error_r <= 1'b1;
        else if (fifo_pop && fifo_word.som)
            tx_underrun_error_r <= 1'b0;
    end

    // Receiver
    assign stripped    = !char_oriented_mode_r && !rx_bit && rx_ones_r == sync_line_pkg::ONES_STUFF;
    assign rx_sr_nxt   = {rx_bit, rx_sr_r[7:1]};
    assign sync_sr_nxt = {rx_bit, sync_sr_r[7:1]};

    always_ff @(posedge sys_clk)
    begin
        if (clr)
        begin
            raw_sr_r       <= 8'h00;
            rx_sr_r        <= 8'h00;
            sync_sr_r      <= 8'h00;
            rx_cnt_r       <= 4'h0;
            rx_ones_r      <= 3'h0;
            first_char_r   <= 1'b0;
            frame_data_r   <= 1'b0;
            rx_crc_r       <= sync_line_pkg::CRC_INIT;
            rx_addr_match  <= 1'b0;
            rx_sync_detect <= 1'b0;
            rx_crc_error   <= 1'b0;
            rx_byte_valid  <= 1'b0;
            rx_byte        <= 8'h00;
        end
        else
        begin
            rx_addr_match  <= 1'b0;
            rx_sync_detect <= 1'b0;
            rx_crc_error   <= 1'b0;
            rx_byte_valid  <= 1'b0;
            if (rx_bit_en && rx_enable)
            begin
                raw_sr_r  <= {rx_bit, raw_sr_r[7:1]};
                sync_sr_r <= sync_sr_nxt;
                rx_ones_r <= rx_bit ? ((rx_ones_r == 3'h7) ? rx_ones_r : rx_ones_r + 3'h1) : 3'h0;
                if (char_oriented_mode_r)
                begin
                    if (sync_sr_nxt == station_addr_or_sync_char_r)
                        rx_sync_detect <= 1'b1;
                end
                else if ({rx_bit, raw_sr_r[7:1]} == sync_line_pkg::FLAG_CHAR)
                begin
                    if (frame_data_r && rx_crc_r != 16'h0000 && !crc_inhibit_r)
                        rx_crc_error <= 1'b1;
                    first_char_r <= 1'b1;
                    frame_data_r <= 1'b0;
                    rx_cnt_r     <= 4'h0;
                    rx_crc_r     <= sync_line_pkg::CRC_INIT;
                end
                else if (!stripped)
                begin
                    rx_sr_r  <= rx_sr_nxt;
                    rx_cnt_r <= rx_cnt_r + 4'h1;
                    if (rx_cnt_r == sync_line_pkg::CHAR_BITS - 4'h1)
                    begin
                        rx_cnt_r      <= 4'h0;
                        rx_byte       <= rx_sr_nxt;
                        rx_byte_valid <= 1'b1;
                        rx_crc_r      <= crc_byte(rx_crc_r, rx_sr_nxt);
                        frame_data_r  <= 1'b1;
                        first_char_r  <= 1'b0;
                        if (first_char_r && sec_mode_r && rx_sr_nxt == station_addr_or_sync_char_r)
                            rx_addr_match <= 1'b1;
                    end
                end
            end
        end
    end

    // Assertions
    sequence s_late_char;
        char_end && !fifo_valid && tx_send && !cur_r.som && !cur_r.eom;
    endsequence

    a_late_sets_error: assert property (@(posedge sys_clk) disable iff (clr)
        s_late_char |=> tx_underrun_error_r) else $error("underrun not flagged");
    a_som_no_error: assert property (@(posedge sys_clk) disable iff (clr)
        (char_end && cur_r.som && !tx_underrun_error_r) |=> !tx_underrun_error_r)
        else $error("underrun after sync char");
    a_som_clears_error: assert property (@(posedge sys_clk) disable iff (clr)
        (fifo_pop && fifo_word.som) |=> !tx_underrun_error_r) else $error("underrun not cleared");
    a_abort_after_late: assert property (@(posedge sys_clk) disable iff (clr)
        (s_late_char ##0 !char_oriented_mode_r) |=> tx_state_r == sync_line_pkg::TX_ABORT)
        else $error("no abort after underrun");
    a_mark_after_late: assert property (@(posedge sys_clk) disable iff (clr)
        (s_late_char ##0 char_oriented_mode_r) |=> tx_state_r == sync_line_pkg::TX_MARK)
        else $error("no mark after underrun");
    a_abort_line_high: assert property (@(posedge sys_clk) disable iff (clr)
        (tx_state_r == sync_line_pkg::TX_ABORT && tx_send && tx_bit_en && !fifo_pop) |=> tx_serial_out)
        else $error("abort line not high");
    a_crc_inhibit_skip: assert property (@(posedge sys_clk) disable iff (clr)
        (crc_inhibit_r && tx_state_r != sync_line_pkg::TX_CRC) |=> tx_state_r != sync_line_pkg::TX_CRC)
        else $error("crc sent while inhibited");
    a_rx_no_crc_check: assert property (@(posedge sys_clk) disable iff (clr)
        $past(crc_inhibit_r) |-> !rx_crc_error) else $error("crc checked while inhibited");
    a_step_one_bit: assert property (@(posedge sys_clk) disable iff (clr)
        (diag_internal_mode && !step_rise && !fifo_pop && tx_send) |=> $stable(tx_serial_out))
        else $error("tx shifted without step");
    a_step_clear_reset: assert property (@(posedge sys_clk)
        rst |=> !diag_step_clock_r && station_addr_or_sync_char_r == 8'h00)
        else $error("reset did not clear");
    a_addr_match_sec: assert property (@(posedge sys_clk) disable iff (clr)
        rx_addr_match |-> sec_mode_r && rx_byte == station_addr_or_sync_char_r && rx_byte_valid)
        else $error("bad address match");
endmodule
`default_nettype wire

// ==== sim/modem_model.sv ====
/*
 * Modem model: transmit and receive bit clocks and receive data.
 * Assumes the bench gates the transmit clock per frame and calls send.
 */
`timescale 1ns/10ps
`default_nettype none
module modem_model (
    // Serial pins
    output logic      modem_tx_clk,
    output logic      modem_rx_clk,
    output logic      modem_rx_data,
    // Frame control
    input  wire logic tx_run
);
    initial
    begin
        modem_tx_clk = 1'b1;
        modem_rx_clk = 1'b0;
        modem_rx_data = 1'b1;
    end
    // Transmit clock stands still outside frames
    always #40 modem_tx_clk = tx_run ? ~modem_tx_clk : 1'b1;
    // LSB first, data changes while the clock is low
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            modem_rx_data = b[i];
            #40 modem_rx_clk = 1'b1;
            #40 modem_rx_clk = 1'b0;
        end
        modem_rx_data = ~modem_rx_data;
    endtask
endmodule
`default_nettype wire

// ==== sim/sync_line_param_tx_control_test.sv ====
/*
 * Bench for the line parameter and transmit control block.
 * Assumes the modem model in modem_model.sv.
 */
`timescale 1ns/10ps
`default_nettype none
module sync_line_param_tx_control_test;
    logic sys_clk = 1'b0, rst = 1'b1, dev_reset = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_sel = 1'b0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, got;
    logic tx_push_valid = 1'b0, tx_push_ready, tx_char_done, tx_send = 1'b0, rx_enable = 1'b0;
    logic diag_internal_mode = 1'b0, tx_run = 1'b0, hit = 1'b0, crc_hit = 1'b0, k_mode = 1'b0, bit_exp;
    logic modem_tx_clk, modem_rx_clk, modem_rx_data, tx_serial_out;
    logic rx_addr_match, rx_sync_detect, rx_crc_error, rx_byte_valid;
    logic [7:0] rx_byte;
    sync_line_pkg::tx_word_t tx_char_buffer = 10'h000;
    int n_errors = 0, n_tests = 0, cyc = 0, zeros;

    sync_line_param_tx_control dut_u (.sys_clk(sys_clk), .rst(rst), .dev_reset(dev_reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_push_valid(tx_push_valid), .tx_push_ready(tx_push_ready), .tx_char_buffer(tx_char_buffer),
        .tx_char_done(tx_char_done), .tx_send(tx_send), .rx_enable(rx_enable),
        .diag_internal_mode(diag_internal_mode), .modem_tx_clk(modem_tx_clk), .modem_rx_clk(modem_rx_clk),
        .modem_rx_data(modem_rx_data), .tx_serial_out(tx_serial_out), .rx_addr_match(rx_addr_match),
        .rx_sync_detect(rx_sync_detect), .rx_crc_error(rx_crc_error), .rx_byte_valid(rx_byte_valid),
        .rx_byte(rx_byte));
    modem_model modem_u (.modem_tx_clk(modem_tx_clk), .modem_rx_clk(modem_rx_clk),
        .modem_rx_data(modem_rx_data), .tx_run(tx_run));

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc++;
        if ((k_mode ? rx_addr_match : rx_sync_detect) === 1'b1)
            hit = 1'b1;
        if (rx_crc_error === 1'b1)
            crc_hit = 1'b1;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] g, input logic [15:0] e, input string m);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic wr(input logic s, input logic [15:0] d);
        @(posedge sys_clk) #1;
        reg_wr = 1'b1;
        reg_sel = s;
        reg_wdata = d;
        @(posedge sys_clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic s);
        @(posedge sys_clk) #1;
        reg_rd = 1'b1;
        reg_sel = s;
        @(posedge sys_clk) #1;
        reg_rd = 1'b0;
        got = reg_rdata;
    endtask
    task automatic push(input sync_line_pkg::tx_word_t w);
        @(posedge sys_clk) #1;
        tx_push_valid = 1'b1;
        tx_char_buffer = w;
        @(posedge sys_clk) #1;
        tx_push_valid = 1'b0;
    endtask
    task automatic pulse_dev_reset();
        @(posedge sys_clk) #1;
        dev_reset = 1'b1;
        @(posedge sys_clk) #1;
        dev_reset = 1'b0;
    endtask
    task automatic poll_late(input logic e);
        got = {~e, 15'h0000};
        for (int i = 0; i < 300 && got[15] !== e; i++)
            rd(1'b1);
        check({15'h0000, got[15]}, {15'h0000, e}, "underrun flag");
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        rd(1'b1);
        check(got, 16'h0000, "transmit_control_status after reset");
        rd(1'b0);
        check(got, 16'h0000, "param reads zero");
        wr(1'b1, 16'hffff);
        rd(1'b1);
        check(got, 16'h2400, "transmit_control_status writable bits");
        pulse_dev_reset();
        rd(1'b1);
        check(got, 16'h0000, "device reset clears");
        for (int i = 0; i < 16; i++)
            push(10'h000);
        check({14'h0000, tx_push_ready, tx_char_done}, 16'h0000, "buffer full");
        pulse_dev_reset();
        check({14'h0000, tx_push_ready, tx_char_done}, 16'h0003, "buffer cleared");
        // Single step a start-of-message character out
        diag_internal_mode = 1'b1;
        tx_send = 1'b1;
        push(10'h2a5);
        for (int i = 0; i < 9; i++)
        begin
            bit_exp = (i == 0) ? 1'b1 : 8'ha5 >> (i - 1);
            wr(1'b1, 16'h2000);
            repeat (2) @(posedge sys_clk);
            check({15'h0000, tx_serial_out}, {15'h0000, bit_exp}, "step out");
            rd(1'b1);
            check(got, {1'b0, bit_exp, 14'h2000}, "monitor bit");
            wr(1'b1, 16'h0000);
        end
        // Late reload in bit mode, then character mode
        diag_internal_mode = 1'b0;
        for (int m = 0; m < 2; m++)
        begin
            pulse_dev_reset();
            wr(1'b0, m ? 16'h8000 : 16'h0000);
            tx_send = 1'b1;
            push(10'h2a5);
            push(10'h03c);
            tx_run = 1'b1;
            poll_late(1'b1);
            repeat (16) @(posedge sys_clk);
            zeros = 0;
            repeat (160) @(posedge sys_clk) zeros += (tx_serial_out === 1'b1) ? 0 : 1;
            check(zeros[15:0], 16'h0000, "line after underrun");
            push(10'h2a5);
            poll_late(1'b0);
            tx_run = 1'b0;
            tx_send = 1'b0;
        end
        // Sync character, then secondary address after a flag
        for (int k = 0; k < 2; k++)
        begin
            pulse_dev_reset();
            k_mode = k[0];
            wr(1'b0, k ? 16'h105a : 16'h8096);
            rx_enable = 1'b1;
            hit = 1'b0;
            modem_u.send(k ? 8'h7e : 8'h96);
            modem_u.send(k ? 8'h5a : 8'h96);
            repeat (20) @(posedge sys_clk);
            check({15'h0000, hit}, 16'h0001, "receive match");
            rx_enable = 1'b0;
        end
        // Diag input bits stepped into the receiver, then receive CRC with and without inhibit
        pulse_dev_reset();
        diag_internal_mode = 1'b1;
        rx_enable = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            bit_exp = 16'h5a7e >> i;
            wr(1'b1, 16'h2000);
            wr(1'b1, {5'h00, bit_exp, 10'h000});
        end
        repeat (2) @(posedge sys_clk);
        check({8'h00, rx_byte}, 16'h005a, "diag input byte");
        diag_internal_mode = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            pulse_dev_reset();
            wr(1'b0, c ? 16'h0200 : 16'h0000);
            rx_enable = 1'b1;
            crc_hit = 1'b0;
            modem_u.send(8'h7e);
            modem_u.send(8'h5a);
            modem_u.send(8'h7e);
            repeat (20) @(posedge sys_clk);
            check({15'h0000, crc_hit}, {15'h0000, c == 0}, "receive crc check");
            check({8'h00, rx_byte}, 16'h005a, "received byte");
            rx_enable = 1'b0;
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
